// ---- logic/phy_id_pkg.sv ----
package phy_id_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int BYTE_W = 8;
  localparam int IDX_W = 4;
  localparam int PAGE_W = 3;
  localparam int PWR_W = 3;
  localparam int STRAP_W = 3;
  localparam int ID_W = 24;

  // Word index inside the map; byte address is four times the index
  localparam logic [IDX_W-1:0] BASE_PWR_IDX = 4'h4;
  localparam logic [IDX_W-1:0] BASE_PAGE_IDX = 4'h7;
  localparam logic [IDX_W-1:0] COMPLIANCE_IDX = 4'h8;
  localparam logic [IDX_W-1:0] ID_PAGE_RSVD_IDX = 4'h9;
  localparam logic [IDX_W-1:0] MAKER_OUI_HIGH_IDX = 4'hA;
  localparam logic [IDX_W-1:0] MAKER_OUI_MID_IDX = 4'hB;
  localparam logic [IDX_W-1:0] MAKER_OUI_LOW_IDX = 4'hC;
  localparam logic [IDX_W-1:0] PART_IDENT_HIGH_IDX = 4'hD;
  localparam logic [IDX_W-1:0] PART_IDENT_MID_IDX = 4'hE;
  localparam logic [IDX_W-1:0] PART_IDENT_LOW_IDX = 4'hF;
  localparam logic [IDX_W-1:0] VENDOR_RESET_CTRL_IDX = 4'hE;
  localparam logic [IDX_W-1:0] EXT_FIRST_IDX = 4'h8;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = IDX_LSB + IDX_W - 1;

  localparam logic [PAGE_W-1:0] PAGE_IDENT = 3'h1;
  localparam logic [PAGE_W-1:0] PAGE_VENDOR = 3'h7;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h0;
  localparam int PAGE_SEL_LSB = 5;
  localparam int PWR_CLASS_LSB = 0;
  localparam int SOFT_RESET_BIT = 7;

  localparam logic [BYTE_W-1:0] COMPLIANCE_LEVEL = 8'h02;
  localparam logic [ID_W-1:0] MAKER_OUI_DEFAULT = 24'hA5_5A_01;
  localparam logic [ID_W-1:0] PART_IDENT_DEFAULT = 24'h00_01_00;

  // Self-ID quadlet: prefix 10b in bits 0-1, pwr in bits 21-23 (bit 0 is MSB)
  localparam logic [DATA_W-1:0] SELF_ID_BASE = 32'h8000_0000;
  localparam int SELF_ID_PWR_LSB = 8;

  typedef enum logic [PWR_W-1:0] {
    PWR_NONE = 3'b000,
    PWR_SELF_15W = 3'b001,
    PWR_SELF_30W = 3'b010,
    PWR_SELF_45W = 3'b011,
    PWR_BUS_PROVIDER = 3'b100,
    PWR_RESERVED = 3'b101,
    PWR_BUS_LINK_3W = 3'b110,
    PWR_BUS_LINK_7W = 3'b111
  } pwr_class_t;

  localparam logic [PWR_W-1:0] PWR_CLASS_RESET = 3'b000;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SOFT_RESET_NS = 200;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 4;
  localparam int STRAP_SETTLE_CYCLES = 2;
  localparam int SETTLE_W = 2;
endpackage

// ---- logic/soft_reset_gen.sv ----
`timescale 1ns/100ps
module soft_reset_gen
  import phy_id_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic soft_req_in,
  output logic core_rst_n_out
);
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic [HOLD_W-1:0] hold_cnt_reg;
  logic core_rst_n_reg;

  // Release of the pin reset is synchronised, assertion is immediate
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      hold_cnt_reg <= '0;
    else if (soft_req_in)
      hold_cnt_reg <= HOLD_W'(SOFT_RESET_CYCLES);
    else if (hold_cnt_reg != '0)
      hold_cnt_reg <= hold_cnt_reg - 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      core_rst_n_reg <= 1'b0;
    else
      core_rst_n_reg <= rst_sync2_reg && (hold_cnt_reg == '0) && !soft_req_in;
  end

  assign core_rst_n_out = core_rst_n_reg;
endmodule

// ---- logic/phy_id_pages_and_power_class.sv ----
`timescale 1ns/100ps
module phy_id_pages_and_power_class
  import phy_id_pkg::*;
#(
  parameter logic [phy_id_pkg::ID_W-1:0] MAKER_OUI = phy_id_pkg::MAKER_OUI_DEFAULT,
  parameter logic [phy_id_pkg::ID_W-1:0] PART_IDENT = phy_id_pkg::PART_IDENT_DEFAULT
)
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [phy_id_pkg::ADDR_W-1:0] PADDR_IN,
  input wire logic [phy_id_pkg::DATA_W-1:0] PWDATA_IN,
  input wire logic [phy_id_pkg::STRB_W-1:0] PSTRB_IN,
  output logic [phy_id_pkg::DATA_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic POWER_CLASS_STRAP_A_IN,
  input wire logic POWER_CLASS_STRAP_B_IN,
  input wire logic POWER_CLASS_STRAP_C_IN,
  input wire logic STRAP_MODE_EN_IN,
  output logic [phy_id_pkg::PWR_W-1:0] POWER_CLASS_OUT,
  output logic [phy_id_pkg::DATA_W-1:0] SELF_ID_QUAD_OUT,
  output logic PWR_SUPPLIER_OUT,
  output logic PWR_LINK_EXTRA_OUT,
  output logic PWR_CLASS_RSVD_OUT,
  output logic [phy_id_pkg::PAGE_W-1:0] PAGE_SELECT_OUT,
  output logic CORE_RST_N_OUT
);
  import phy_id_pkg::*;

  logic core_rst_n;
  logic soft_req_reg;
  logic soft_req_next;

  logic [STRAP_W-1:0] strap_raw;
  logic [STRAP_W-1:0] strap_meta_reg;
  logic [STRAP_W-1:0] strap_sync_reg;
  logic mode_meta_reg;
  logic mode_sync_reg;

  logic strap_pending_reg;
  logic [SETTLE_W-1:0] settle_cnt_reg;

  logic [PAGE_W-1:0] page_sel_reg;
  logic [PWR_W-1:0] pwr_class_reg;
  logic [PWR_W-1:0] pwr_class_next;

  logic pready_reg;
  logic pslverr_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] self_id_reg;
  logic supplier_reg;
  logic link_extra_reg;
  logic rsvd_code_reg;

  logic access;
  logic commit;
  logic wr_commit;
  logic addr_ok;
  logic [IDX_W-1:0] idx;
  logic [BYTE_W-1:0] wr_byte;
  logic lane0_en;
  logic [BYTE_W-1:0] rd_byte;
  logic ident_page;
  logic vendor_page;
  logic ext_idx;
  logic answer_due;
  logic pwr_wr;
  logic page_wr;
  logic soft_reset_wr;
  logic strap_load;
  logic supplier_next;
  logic link_extra_next;
  logic rsvd_code_next;
  logic [DATA_W-1:0] self_id_next;

  soft_reset_gen u_soft_reset_gen
  (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .soft_req_in(soft_req_reg),
    .core_rst_n_out(core_rst_n)
  );

  // Straps are pins from outside the clock domain
  assign strap_raw = {POWER_CLASS_STRAP_A_IN, POWER_CLASS_STRAP_B_IN,
    POWER_CLASS_STRAP_C_IN};

  generate
    for (genvar i = 0; i < STRAP_W; i++)
    begin : g_strap_sync
      always_ff @(posedge CLK_IN or negedge core_rst_n)
      begin
        if (!core_rst_n)
        begin
          strap_meta_reg[i] <= 1'b0;
          strap_sync_reg[i] <= 1'b0;
        end
        else
        begin
          strap_meta_reg[i] <= strap_raw[i];
          strap_sync_reg[i] <= strap_meta_reg[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
    end
    else
    begin
      mode_meta_reg <= STRAP_MODE_EN_IN;
      mode_sync_reg <= mode_meta_reg;
    end
  end

  // APB decode
  assign access = PSEL_IN && PENABLE_IN;
  assign commit = access && pready_reg;
  assign addr_ok = (PADDR_IN[ADDR_W-1:IDX_MSB+1] == '0) && (PADDR_IN[IDX_LSB-1:0] == '0);
  assign idx = PADDR_IN[IDX_MSB:IDX_LSB];
  assign wr_byte = PWDATA_IN[BYTE_W-1:0];
  assign lane0_en = PSTRB_IN[0];
  assign wr_commit = commit && PWRITE_IN && addr_ok && lane0_en;
  assign ident_page = (page_sel_reg == PAGE_IDENT);
  assign vendor_page = (page_sel_reg == PAGE_VENDOR);
  assign ext_idx = (idx >= EXT_FIRST_IDX);

  // Access seen and not yet answered
  assign answer_due = access && !pready_reg;
  // Write strobes for the stored fields
  assign pwr_wr = wr_commit && (idx == BASE_PWR_IDX);
  assign page_wr = wr_commit && (idx == BASE_PAGE_IDX);
  assign soft_reset_wr = wr_commit && vendor_page && (idx == VENDOR_RESET_CTRL_IDX);

  // Read data for the current index and page
  always_comb
  begin
    rd_byte = '0;
    if (!ext_idx)
    begin
      if (idx == BASE_PWR_IDX)
        rd_byte[PWR_CLASS_LSB +: PWR_W] = pwr_class_reg;
      else if (idx == BASE_PAGE_IDX)
        rd_byte[PAGE_SEL_LSB +: PAGE_W] = page_sel_reg;
    end
    else if (ident_page)
    begin
      unique case (idx)
        COMPLIANCE_IDX: rd_byte = COMPLIANCE_LEVEL;
        MAKER_OUI_HIGH_IDX: rd_byte = MAKER_OUI[ID_W-1 -: BYTE_W];
        MAKER_OUI_MID_IDX: rd_byte = MAKER_OUI[ID_W-BYTE_W-1 -: BYTE_W];
        MAKER_OUI_LOW_IDX: rd_byte = MAKER_OUI[BYTE_W-1:0];
        PART_IDENT_HIGH_IDX: rd_byte = PART_IDENT[ID_W-1 -: BYTE_W];
        PART_IDENT_MID_IDX: rd_byte = PART_IDENT[ID_W-BYTE_W-1 -: BYTE_W];
        PART_IDENT_LOW_IDX: rd_byte = PART_IDENT[BYTE_W-1:0];
        default: rd_byte = '0;
      endcase
    end
    else if (vendor_page)
    begin
      // Soft reset bit is write-only; test locations stay hidden
      unique case (idx)
        VENDOR_RESET_CTRL_IDX: rd_byte = '0;
        default: rd_byte = '0;
      endcase
    end
    else
    begin
      // No other page has anything behind the extension locations
      rd_byte = '0;
    end
  end

  // One wait state: ready in the second access cycle
  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      pready_reg <= 1'b0;
    else
      pready_reg <= answer_due;
  end

  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      pslverr_reg <= 1'b0;
    else if (answer_due)
      pslverr_reg <= !addr_ok;
    else
      pslverr_reg <= 1'b0;
  end

  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      prdata_reg <= '0;
    else if (answer_due && !PWRITE_IN && addr_ok)
      prdata_reg <= {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
    else if (!access)
      prdata_reg <= '0;
  end

  // Page selector
  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      page_sel_reg <= PAGE_RESET;
    else if (page_wr)
      page_sel_reg <= wr_byte[PAGE_SEL_LSB +: PAGE_W];
  end

  // Soft reset request, one-cycle pulse
  always_comb
  begin
    soft_req_next = 1'b0;
    if (soft_reset_wr)
      soft_req_next = wr_byte[SOFT_RESET_BIT];
  end

  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      soft_req_reg <= 1'b0;
    else
      soft_req_reg <= soft_req_next;
  end

  // Wait for the strap synchroniser to fill after each reset
  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      settle_cnt_reg <= '0;
    else if (strap_pending_reg && !strap_load)
      settle_cnt_reg <= settle_cnt_reg + 1'b1;
  end

  // Class default is taken once, when the synchroniser has settled
  assign strap_load = strap_pending_reg && (settle_cnt_reg == SETTLE_W'(STRAP_SETTLE_CYCLES));

  // Pending until the strap load or a software write to the class
  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      strap_pending_reg <= 1'b1;
    else if (pwr_wr)
      strap_pending_reg <= 1'b0;
    else if (strap_load)
      strap_pending_reg <= 1'b0;
  end

  // Power class: strap default, software write wins
  always_comb
  begin
    pwr_class_next = pwr_class_reg;
    if (pwr_wr)
      pwr_class_next = wr_byte[PWR_CLASS_LSB +: PWR_W];
    else if (strap_load)
    begin
      if (mode_sync_reg)
        pwr_class_next = strap_sync_reg;
      else
        pwr_class_next = PWR_CLASS_RESET;
    end
  end

  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      pwr_class_reg <= PWR_CLASS_RESET;
    else
      pwr_class_reg <= pwr_class_next;
  end

  // Self-ID quadlet carries the class in its pwr field
  always_comb
  begin
    self_id_next = SELF_ID_BASE;
    self_id_next[SELF_ID_PWR_LSB +: PWR_W] = pwr_class_next;
  end

  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      self_id_reg <= SELF_ID_BASE;
    else
      self_id_reg <= self_id_next;
  end

  // Decoded meaning of the class code
  always_comb
  begin
    supplier_next = 1'b0;
    link_extra_next = 1'b0;
    rsvd_code_next = 1'b0;
    unique case (pwr_class_t'(pwr_class_next))
      PWR_NONE: supplier_next = 1'b0;
      PWR_SELF_15W, PWR_SELF_30W, PWR_SELF_45W: supplier_next = 1'b1;
      PWR_BUS_PROVIDER: supplier_next = 1'b1;
      PWR_RESERVED: rsvd_code_next = 1'b1;
      PWR_BUS_LINK_3W, PWR_BUS_LINK_7W: link_extra_next = 1'b1;
    endcase
  end

  // Flags load with the class so the class, flag and self-ID outputs change together
  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      supplier_reg <= 1'b0;
    else
      supplier_reg <= supplier_next;
  end

  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      link_extra_reg <= 1'b0;
    else
      link_extra_reg <= link_extra_next;
  end

  always_ff @(posedge CLK_IN or negedge core_rst_n)
  begin
    if (!core_rst_n)
      rsvd_code_reg <= 1'b0;
    else
      rsvd_code_reg <= rsvd_code_next;
  end

  assign PRDATA_OUT = prdata_reg;
  assign PREADY_OUT = pready_reg;
  assign PSLVERR_OUT = pslverr_reg;
  assign POWER_CLASS_OUT = pwr_class_reg;
  assign SELF_ID_QUAD_OUT = self_id_reg;
  assign PWR_SUPPLIER_OUT = supplier_reg;
  assign PWR_LINK_EXTRA_OUT = link_extra_reg;
  assign PWR_CLASS_RSVD_OUT = rsvd_code_reg;
  assign PAGE_SELECT_OUT = page_sel_reg;
  assign CORE_RST_N_OUT = core_rst_n;
endmodule

// ---- test/link_ctrl_model.sv ----
`timescale 1ns/100ps
module link_ctrl_model
(
  input wire logic clk_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  input wire logic [31:0] prdata_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out,
  output logic [3:0] pstrb_out
);
  initial
  begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
    pstrb_out = 4'hF;
  end

  // One APB transfer; returns right after the edge that sampled ready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    @(posedge clk_in);
    // Only the bench watchdog ends a wait for ready
    while (pready_in !== 1'b1)
      @(posedge clk_in);
    q = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // Released data lines must not keep the last value
    pwdata_out <= ~d;
  endtask
endmodule

// ---- test/phy_id_assertions.sv ----
`timescale 1ns/100ps
module phy_id_checker
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [2:0] POWER_CLASS_OUT,
  input wire logic [31:0] SELF_ID_QUAD_OUT,
  input wire logic PWR_SUPPLIER_OUT,
  input wire logic PWR_LINK_EXTRA_OUT,
  input wire logic PWR_CLASS_RSVD_OUT,
  input wire logic [2:0] PAGE_SELECT_OUT,
  input wire logic CORE_RST_N_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire acc = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire rd_ok = acc & ~PWRITE_IN;
  wire wr_ok = acc & PWRITE_IN & PSTRB_IN[0] & ~PSLVERR_OUT;
  wire [2:0] wpage = PWDATA_IN[7:5];
  wire [2:0] pc = POWER_CLASS_OUT;
  wire [2:0] wclass = PWDATA_IN[2:0];

  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready held");
  ready_wait_a: assert property ($rose(PENABLE_IN) && PSEL_IN && CORE_RST_N_OUT
    |-> !PREADY_OUT ##1 PREADY_OUT) else $error("ready late");
  bad_addr_err_a: assert property (acc && PADDR_IN[1:0] != 2'b00 |-> PSLVERR_OUT)
    else $error("no error on bad address");
  compliance_read_a: assert property (
    rd_ok && PADDR_IN == 8'h20 && PAGE_SELECT_OUT == 3'h1 |-> PRDATA_OUT == 32'h02)
    else $error("compliance value wrong");
  reset_bit_read_a: assert property (
    rd_ok && PADDR_IN == 8'h38 && PAGE_SELECT_OUT == 3'h7 |-> !PRDATA_OUT[7])
    else $error("soft reset bit reads 1");
  page_write_a: assert property (wr_ok && PADDR_IN == 8'h1C
    |=> PAGE_SELECT_OUT == $past(wpage)) else $error("page not taken");
  soft_reset_a: assert property (wr_ok && PADDR_IN == 8'h38 && PWDATA_IN[7]
    && PAGE_SELECT_OUT == 3'h7 |-> ##2 !CORE_RST_N_OUT [*3]) else $error("no soft reset");
  self_id_field_a: assert property (
    SELF_ID_QUAD_OUT == {21'h10_0000, pc, 8'h00}) else $error("self id field wrong");
  class_decode_a: assert property (PWR_SUPPLIER_OUT == (pc >= 3'h1 && pc <= 3'h4)
    && PWR_LINK_EXTRA_OUT == (pc[2:1] == 2'b11) && PWR_CLASS_RSVD_OUT == (pc == 3'h5))
    else $error("class decode wrong");
  class_write_a: assert property (wr_ok && PADDR_IN == 8'h10
    |=> POWER_CLASS_OUT == $past(wclass)) else $error("class write not taken");
  reserved_read_a: assert property (
    rd_ok && PADDR_IN == 8'h24 && PAGE_SELECT_OUT == 3'h1 |-> PRDATA_OUT == 32'h0)
    else $error("reserved location not zero");
endmodule

bind phy_id_pages_and_power_class phy_id_checker u_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .POWER_CLASS_OUT(POWER_CLASS_OUT),
  .SELF_ID_QUAD_OUT(SELF_ID_QUAD_OUT), .PWR_SUPPLIER_OUT(PWR_SUPPLIER_OUT),
  .PWR_LINK_EXTRA_OUT(PWR_LINK_EXTRA_OUT), .PWR_CLASS_RSVD_OUT(PWR_CLASS_RSVD_OUT),
  .PAGE_SELECT_OUT(PAGE_SELECT_OUT), .CORE_RST_N_OUT(CORE_RST_N_OUT));

// ---- test/tb.sv ----
`timescale 1ns/100ps
module tb;
  import phy_id_pkg::*;
  localparam logic [47:0] IDS = {MAKER_OUI_DEFAULT, PART_IDENT_DEFAULT};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode_en = 1'b1;
  logic [2:0] strap = 3'b110;
  logic psel, penable, pwrite, pready, pslverr, e, sup, ext, rsv, core;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, sid;
  logic [3:0] pstrb;
  logic [2:0] pclass, page;
  int bad_count = 0;
  int cmp_count = 0;

  always #25 clk = ~clk;

  link_ctrl_model link (.clk_in(clk), .pready_in(pready), .pslverr_in(pslverr),
    .prdata_in(prdata), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb));

  phy_id_pages_and_power_class dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .POWER_CLASS_STRAP_A_IN(strap[2]), .POWER_CLASS_STRAP_B_IN(strap[1]),
    .POWER_CLASS_STRAP_C_IN(strap[0]), .STRAP_MODE_EN_IN(mode_en),
    .POWER_CLASS_OUT(pclass), .SELF_ID_QUAD_OUT(sid), .PWR_SUPPLIER_OUT(sup),
    .PWR_LINK_EXTRA_OUT(ext), .PWR_CLASS_RSVD_OUT(rsv), .PAGE_SELECT_OUT(page),
    .CORE_RST_N_OUT(core));

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    link.xfer(1'b0, a, 32'h0, q, e);
    check("read data", q, exp);
  endtask

  // Extra edge lets the write land before outputs are compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    link.xfer(1'b1, a, d, q, e);
    @(posedge clk);
  endtask

  task automatic wait_core(input logic lvl);
    int n;
    n = 0;
    while (core !== lvl && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    check("core reset", core, lvl);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #100000;
    bad_count++;
    end_sim;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_core(1'b1);
    repeat (4) @(posedge clk);
    check("strap class", pclass, 32'h6);
    check("self id", sid, 32'h8000_0600);
    $display("strap test done");
    wr(8'h1C, 32'h20);
    check("page", page, 32'h1);
    rd(8'h20, 32'h02);
    wr(8'h20, 32'hFF);
    rd(8'h20, 32'h02);
    for (int i = 0; i < 6; i++)
      rd(8'(8'h28 + 4 * i), {24'h0, IDS[47 - 8 * i -: 8]});
    rd(8'h24, 32'h0);
    link.xfer(1'b0, 8'h21, 32'h0, q, e);
    check("bad address error", e, 32'h1);
    $display("identification test done");
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h10, c);
      check("class", pclass, c);
      check("self id", sid, 32'h8000_0000 | (c << 8));
      check("decode", {sup, ext, rsv}, {c >= 1 && c <= 4, c >= 6, c == 5});
    end
    $display("power class test done");
    wr(8'h1C, 32'hE0);
    check("page", page, 32'h7);
    rd(8'h38, 32'h0);
    wr(8'h2C, 32'hFF);
    rd(8'h2C, 32'h0);
    strap <= 3'b011;
    wr(8'h38, 32'h80);
    wait_core(1'b0);
    wait_core(1'b1);
    repeat (4) @(posedge clk);
    check("page after reset", page, 32'h0);
    check("class after reset", pclass, 32'h3);
    mode_en <= 1'b0;
    wr(8'h1C, 32'hE0);
    wr(8'h38, 32'h80);
    wait_core(1'b0);
    wait_core(1'b1);
    repeat (4) @(posedge clk);
    check("class without straps", pclass, 32'h0);
    $display("soft reset test done");
    end_sim;
  end
endmodule
